/* File: iod_pkg.sv */
package iod_pkg;
  localparam int IO_AW = 6;
  localparam int DA_AW = 8;
  localparam logic [5:0] IO_FIRST = 6'h00;
  localparam logic [5:0] IO_LAST = 6'h3F;
  localparam logic [7:0] DATA_IO_OFFSET = 8'h20;
  localparam logic [7:0] EXT_FIRST = 8'h60;
  localparam logic [7:0] EXT_LAST = 8'hFF;
  localparam logic [5:0] BIT_LAST = 6'h1F;
  localparam logic [5:0] A_INPB = 6'h03;
  localparam logic [5:0] A_DIRB = 6'h04;
  localparam logic [5:0] A_OUTB = 6'h05;
  localparam logic [5:0] A_INPC = 6'h06;
  localparam logic [5:0] A_DIRC = 6'h07;
  localparam logic [5:0] A_OUTC = 6'h08;
  localparam logic [5:0] A_INPD = 6'h09;
  localparam logic [5:0] A_DIRD = 6'h0A;
  localparam logic [5:0] A_OUTD = 6'h0B;
  localparam logic [5:0] A_INPA = 6'h0C;
  localparam logic [5:0] A_DIRA = 6'h0D;
  localparam logic [5:0] A_OUTA = 6'h0E;
  localparam logic [5:0] A_PCR = 6'h12;
  localparam logic [5:0] A_T0F = 6'h15;
  localparam logic [5:0] A_T1F = 6'h16;
  localparam logic [5:0] A_PCF = 6'h1B;
  localparam logic [5:0] A_EXF = 6'h1C;
  localparam logic [5:0] A_EXM = 6'h1D;
  localparam logic [5:0] A_SCR0 = 6'h1E;
  localparam logic [5:0] A_NVMC = 6'h1F;
  localparam logic [5:0] A_NVMD = 6'h20;
  localparam logic [5:0] A_NVMA = 6'h21;
  localparam logic [5:0] A_TPS = 6'h23;
  localparam logic [5:0] A_T0C = 6'h25;
  localparam logic [5:0] A_T0N = 6'h26;
  localparam logic [5:0] A_T0A = 6'h27;
  localparam logic [5:0] A_T0B = 6'h28;
  localparam logic [5:0] A_SCR1 = 6'h2A;
  localparam logic [5:0] A_SCR2 = 6'h2B;
  localparam logic [7:0] M_T0F = 8'h07;
  localparam logic [7:0] M_T1F = 8'h27;
  localparam logic [7:0] M_PCF = 8'h0F;
  localparam logic [7:0] M_EXF = 8'h03;
  localparam logic [7:0] M_EXM = 8'h03;
  localparam logic [7:0] M_PA = 8'h0F;
  localparam logic [7:0] M_NVMC = 8'h3F;
  localparam logic [7:0] M_TPS = 8'h81;
  localparam logic [7:0] M_T0C = 8'h0F;
  localparam logic [7:0] RST_VAL = 8'h00;
  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_IN    = 3'h1,
    OP_OUT   = 3'h2,
    OP_LOAD  = 3'h3,
    OP_STORE = 3'h4,
    OP_SETB  = 3'h5,
    OP_CLRB  = 3'h6,
    OP_TESTB = 3'h7
  } iod_op_t;
endpackage

/* File: iod_acc_if.sv */
`timescale 1ns/100ps
interface iod_acc_if;
  logic       valid;
  iod_pkg::iod_op_t op;
  logic [7:0] addr;
  logic [2:0] bsel;
  logic       io_hit;
  logic [5:0] io_addr;
  logic       ext_hit;
  logic       bit_ok;
  logic       wr;
  logic       rd;
  modport dec (input valid, op, addr, bsel, output io_hit, io_addr, ext_hit, bit_ok, wr, rd);
  modport use_side (input io_hit, io_addr, ext_hit, bit_ok, wr, rd, bsel, op);
endinterface

/* File: iod_decode.sv */
`timescale 1ns/100ps
module iod_decode (
  iod_acc_if.dec a
);
  logic io_form;
  logic data_form;
  logic bit_form;
  always_comb begin
    io_form   = a.valid && (a.op == iod_pkg::OP_IN || a.op == iod_pkg::OP_OUT);
    bit_form  = a.valid && (a.op == iod_pkg::OP_SETB || a.op == iod_pkg::OP_CLRB || a.op == iod_pkg::OP_TESTB);
    data_form = a.valid && (a.op == iod_pkg::OP_LOAD || a.op == iod_pkg::OP_STORE);
    a.io_addr = a.addr[5:0];
    a.io_hit  = 1'b0;
    a.ext_hit = 1'b0;
    a.bit_ok  = 1'b0;
    if (io_form) begin
      a.io_hit = (a.addr[7:6] == 2'h0);
    end else if (bit_form) begin
      a.bit_ok = (a.addr[7:5] == 3'h0);
      a.io_hit = a.bit_ok;
    end else if (data_form) begin
      if (a.addr >= iod_pkg::DATA_IO_OFFSET && a.addr < iod_pkg::EXT_FIRST) begin
        a.io_hit  = 1'b1;
        a.io_addr = 6'(a.addr - iod_pkg::DATA_IO_OFFSET);
      end
      a.ext_hit = (a.addr >= iod_pkg::EXT_FIRST);
    end
    a.wr = a.op == iod_pkg::OP_OUT || a.op == iod_pkg::OP_STORE || a.op == iod_pkg::OP_SETB || a.op == iod_pkg::OP_CLRB;
    a.rd = a.op == iod_pkg::OP_IN || a.op == iod_pkg::OP_LOAD;
  end
endmodule

/* File: iod_regs.sv */
`timescale 1ns/100ps
// What this block does
// - I/O instructions use addresses 0x00 to 0x3F
// - Data-space access adds 0x20 to I/O address
// - Extended 0x60-0xFF only via load/store
// - Bit set/clear only on 0x00-0x1F
// - Bit test reports selected bit state on 0x00-0x1F
// - Flags clear on one, zero leaves unchanged
// - Bit ops write only the addressed bit
module iod_regs (
  input  wire logic                SYS_CLK_I,
  input  wire logic                RST_I,
  input  wire logic                ACC_VALID_I,
  input  wire iod_pkg::iod_op_t    ACC_OP_I,
  input  wire logic [7:0]          ACC_ADDR_I,
  input  wire logic [2:0]          ACC_BIT_I,
  input  wire logic [7:0]          ACC_WDATA_I,
  input  wire logic [7:0]          PIN_A_I,
  input  wire logic [7:0]          PIN_B_I,
  input  wire logic [7:0]          PIN_C_I,
  input  wire logic [7:0]          PIN_D_I,
  input  wire logic [7:0]          T0_FLAG_SET_I,
  input  wire logic [7:0]          T1_FLAG_SET_I,
  input  wire logic [7:0]          PC_FLAG_SET_I,
  input  wire logic [7:0]          EX_FLAG_SET_I,
  input  wire logic [7:0]          EXT_RDATA_I,
  output logic [7:0]               ACC_RDATA_O,
  output logic                     ACC_RVALID_O,
  output logic                     BIT_TEST_O,
  output logic                     EXT_SEL_O,
  output logic                     EXT_WR_O,
  output logic [7:0]               EXT_ADDR_O,
  output logic [7:0]               EXT_WDATA_O,
  output logic [7:0]               DIR_A_O,
  output logic [7:0]               DIR_B_O,
  output logic [7:0]               DIR_C_O,
  output logic [7:0]               DIR_D_O,
  output logic [7:0]               OUT_A_O,
  output logic [7:0]               OUT_B_O,
  output logic [7:0]               OUT_C_O,
  output logic [7:0]               OUT_D_O,
  output logic [7:0]               PULL_CTRL_O,
  output logic [7:0]               EX_MASK_O,
  output logic [7:0]               NVM_CTRL_O,
  output logic [7:0]               NVM_DATA_O,
  output logic [7:0]               NVM_ADDR_O,
  output logic [7:0]               TPS_CTRL_O,
  output logic [7:0]               T0_CTRL_O,
  output logic [7:0]               T0_COUNT_O,
  output logic [7:0]               T0_CMPA_O,
  output logic [7:0]               T0_CMPB_O
);
  iod_acc_if acc ();
  logic [7:0] pa_s1_q, pa_s2_q;
  logic [7:0] pb_s1_q, pb_s2_q;
  logic [7:0] pc_s1_q, pc_s2_q;
  logic [7:0] pd_s1_q, pd_s2_q;
  logic [7:0] t0f_q, t1f_q, pcf_q, exf_q;
  logic [7:0] scr0_q, scr1_q, scr2_q;
  logic [7:0] cur;
  logic [7:0] bmask;
  logic [7:0] wval;
  logic [7:0] w1c;
  logic       we;
  logic       is_bitop;

  assign acc.valid = ACC_VALID_I;
  assign acc.op    = ACC_OP_I;
  assign acc.addr  = ACC_ADDR_I;
  assign acc.bsel  = ACC_BIT_I;

  iod_decode u_dec (
    .a (acc)
  );

  // Pins come from outside the clock domain
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pa_s1_q <= iod_pkg::RST_VAL;
      pa_s2_q <= iod_pkg::RST_VAL;
      pb_s1_q <= iod_pkg::RST_VAL;
      pb_s2_q <= iod_pkg::RST_VAL;
      pc_s1_q <= iod_pkg::RST_VAL;
      pc_s2_q <= iod_pkg::RST_VAL;
      pd_s1_q <= iod_pkg::RST_VAL;
      pd_s2_q <= iod_pkg::RST_VAL;
    end else begin
      pa_s1_q <= PIN_A_I;
      pa_s2_q <= pa_s1_q;
      pb_s1_q <= PIN_B_I;
      pb_s2_q <= pb_s1_q;
      pc_s1_q <= PIN_C_I;
      pc_s2_q <= pc_s1_q;
      pd_s1_q <= PIN_D_I;
      pd_s2_q <= pd_s1_q;
    end
  end

  // Current value of the addressed I/O register
  always_comb begin
    cur = 8'h00;
    case (acc.io_addr)
      iod_pkg::A_INPA: cur = pa_s2_q & iod_pkg::M_PA;
      iod_pkg::A_DIRA: cur = DIR_A_O;
      iod_pkg::A_OUTA: cur = OUT_A_O;
      iod_pkg::A_INPB: cur = pb_s2_q;
      iod_pkg::A_DIRB: cur = DIR_B_O;
      iod_pkg::A_OUTB: cur = OUT_B_O;
      iod_pkg::A_INPC: cur = pc_s2_q;
      iod_pkg::A_DIRC: cur = DIR_C_O;
      iod_pkg::A_OUTC: cur = OUT_C_O;
      iod_pkg::A_INPD: cur = pd_s2_q;
      iod_pkg::A_DIRD: cur = DIR_D_O;
      iod_pkg::A_OUTD: cur = OUT_D_O;
      iod_pkg::A_PCR:  cur = PULL_CTRL_O;
      iod_pkg::A_T0F:  cur = t0f_q;
      iod_pkg::A_T1F:  cur = t1f_q;
      iod_pkg::A_PCF:  cur = pcf_q;
      iod_pkg::A_EXF:  cur = exf_q;
      iod_pkg::A_EXM:  cur = EX_MASK_O;
      iod_pkg::A_SCR0: cur = scr0_q;
      iod_pkg::A_NVMC: cur = NVM_CTRL_O;
      iod_pkg::A_NVMD: cur = NVM_DATA_O;
      iod_pkg::A_NVMA: cur = NVM_ADDR_O;
      iod_pkg::A_TPS:  cur = TPS_CTRL_O;
      iod_pkg::A_T0C:  cur = T0_CTRL_O;
      iod_pkg::A_T0N:  cur = T0_COUNT_O;
      iod_pkg::A_T0A:  cur = T0_CMPA_O;
      iod_pkg::A_T0B:  cur = T0_CMPB_O;
      iod_pkg::A_SCR1: cur = scr1_q;
      iod_pkg::A_SCR2: cur = scr2_q;
      default:         cur = 8'h00;
    endcase
  end

  // Write value and one-to-clear pattern per access kind
  always_comb begin
    bmask    = 8'h01 << acc.bsel;
    is_bitop = ACC_OP_I == iod_pkg::OP_SETB || ACC_OP_I == iod_pkg::OP_CLRB;
    we       = acc.io_hit && acc.wr && (!is_bitop || acc.bit_ok);
    wval     = ACC_WDATA_I;
    w1c      = ACC_WDATA_I;
    if (ACC_OP_I == iod_pkg::OP_SETB) begin
      wval = cur | bmask;
      w1c  = bmask;
    end else if (ACC_OP_I == iod_pkg::OP_CLRB) begin
      wval = cur & ~bmask;
      w1c  = 8'h00;
    end
  end

  // Plain read/write registers; unlisted addresses drop writes
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      DIR_A_O     <= iod_pkg::RST_VAL;
      DIR_B_O     <= iod_pkg::RST_VAL;
      DIR_C_O     <= iod_pkg::RST_VAL;
      DIR_D_O     <= iod_pkg::RST_VAL;
      OUT_A_O     <= iod_pkg::RST_VAL;
      OUT_B_O     <= iod_pkg::RST_VAL;
      OUT_C_O     <= iod_pkg::RST_VAL;
      OUT_D_O     <= iod_pkg::RST_VAL;
      PULL_CTRL_O <= iod_pkg::RST_VAL;
      EX_MASK_O   <= iod_pkg::RST_VAL;
      scr0_q      <= iod_pkg::RST_VAL;
      scr1_q      <= iod_pkg::RST_VAL;
      scr2_q      <= iod_pkg::RST_VAL;
      NVM_CTRL_O  <= iod_pkg::RST_VAL;
      NVM_DATA_O  <= iod_pkg::RST_VAL;
      NVM_ADDR_O  <= iod_pkg::RST_VAL;
      TPS_CTRL_O  <= iod_pkg::RST_VAL;
      T0_CTRL_O   <= iod_pkg::RST_VAL;
      T0_COUNT_O  <= iod_pkg::RST_VAL;
      T0_CMPA_O   <= iod_pkg::RST_VAL;
      T0_CMPB_O   <= iod_pkg::RST_VAL;
    end else if (we) begin
      case (acc.io_addr)
        iod_pkg::A_DIRA: DIR_A_O     <= wval & iod_pkg::M_PA;
        iod_pkg::A_OUTA: OUT_A_O     <= wval & iod_pkg::M_PA;
        iod_pkg::A_DIRB: DIR_B_O     <= wval;
        iod_pkg::A_OUTB: OUT_B_O     <= wval;
        iod_pkg::A_DIRC: DIR_C_O     <= wval;
        iod_pkg::A_OUTC: OUT_C_O     <= wval;
        iod_pkg::A_DIRD: DIR_D_O     <= wval;
        iod_pkg::A_OUTD: OUT_D_O     <= wval;
        iod_pkg::A_PCR:  PULL_CTRL_O <= wval;
        iod_pkg::A_EXM:  EX_MASK_O   <= wval & iod_pkg::M_EXM;
        iod_pkg::A_SCR0: scr0_q      <= wval;
        iod_pkg::A_NVMC: NVM_CTRL_O  <= wval & iod_pkg::M_NVMC;
        iod_pkg::A_NVMD: NVM_DATA_O  <= wval;
        iod_pkg::A_NVMA: NVM_ADDR_O  <= wval;
        iod_pkg::A_TPS:  TPS_CTRL_O  <= wval & iod_pkg::M_TPS;
        iod_pkg::A_T0C:  T0_CTRL_O   <= wval & iod_pkg::M_T0C;
        iod_pkg::A_T0N:  T0_COUNT_O  <= wval;
        iod_pkg::A_T0A:  T0_CMPA_O   <= wval;
        iod_pkg::A_T0B:  T0_CMPB_O   <= wval;
        iod_pkg::A_SCR1: scr1_q      <= wval;
        iod_pkg::A_SCR2: scr2_q      <= wval;
        default: ;
      endcase
    end
  end

  // Sticky flags: a set in the same cycle as a clear wins
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      t0f_q <= iod_pkg::RST_VAL;
      t1f_q <= iod_pkg::RST_VAL;
      pcf_q <= iod_pkg::RST_VAL;
      exf_q <= iod_pkg::RST_VAL;
    end else begin
      t0f_q <= ((t0f_q & ~((we && acc.io_addr == iod_pkg::A_T0F) ? w1c : 8'h00)) | T0_FLAG_SET_I)
               & iod_pkg::M_T0F;
      t1f_q <= ((t1f_q & ~((we && acc.io_addr == iod_pkg::A_T1F) ? w1c : 8'h00)) | T1_FLAG_SET_I)
               & iod_pkg::M_T1F;
      pcf_q <= ((pcf_q & ~((we && acc.io_addr == iod_pkg::A_PCF) ? w1c : 8'h00)) | PC_FLAG_SET_I)
               & iod_pkg::M_PCF;
      exf_q <= ((exf_q & ~((we && acc.io_addr == iod_pkg::A_EXF) ? w1c : 8'h00)) | EX_FLAG_SET_I)
               & iod_pkg::M_EXF;
    end
  end

  // Read answer and bit test, one cycle after the request
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ACC_RDATA_O  <= 8'h00;
      ACC_RVALID_O <= 1'b0;
      BIT_TEST_O   <= 1'b0;
    end else begin
      ACC_RVALID_O <= ACC_VALID_I && (acc.rd || ACC_OP_I == iod_pkg::OP_TESTB);
      if (acc.io_hit && acc.rd) begin
        ACC_RDATA_O <= cur;
      end else if (acc.ext_hit && acc.rd) begin
        ACC_RDATA_O <= EXT_RDATA_I;
      end else begin
        ACC_RDATA_O <= 8'h00;
      end
      BIT_TEST_O <= ACC_OP_I == iod_pkg::OP_TESTB && acc.bit_ok && cur[acc.bsel];
    end
  end

  // Extended range is passed out only for load/store
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      EXT_SEL_O   <= 1'b0;
      EXT_WR_O    <= 1'b0;
      EXT_ADDR_O  <= 8'h00;
      EXT_WDATA_O <= 8'h00;
    end else begin
      EXT_SEL_O   <= acc.ext_hit;
      EXT_WR_O    <= acc.ext_hit && acc.wr;
      EXT_ADDR_O  <= ACC_ADDR_I;
      EXT_WDATA_O <= ACC_WDATA_I;
    end
  end
endmodule

/* File: iod_regs_assertions.sv */
`timescale 1ns/100ps
module iod_regs_assertions (
  input wire logic             SYS_CLK_I,
  input wire logic             RST_I,
  input wire logic             ACC_VALID_I,
  input wire iod_pkg::iod_op_t ACC_OP_I,
  input wire logic [7:0]       ACC_ADDR_I,
  input wire logic [2:0]       ACC_BIT_I,
  input wire logic [7:0]       ACC_WDATA_I,
  input wire logic [7:0]       ACC_RDATA_O,
  input wire logic             ACC_RVALID_O,
  input wire logic             BIT_TEST_O,
  input wire logic             EXT_SEL_O,
  input wire logic             EXT_WR_O,
  input wire logic [7:0]       EXT_ADDR_O,
  input wire logic [7:0]       EXT_WDATA_O,
  input wire logic [7:0]       OUT_B_O,
  input wire logic [7:0]       NVM_DATA_O
);
  logic ext_req;
  logic sel_bit;
  assign ext_req = ACC_VALID_I && ACC_ADDR_I >= 8'h60 &&
                   ACC_OP_I inside {iod_pkg::OP_LOAD, iod_pkg::OP_STORE};
  assign sel_bit = OUT_B_O[ACC_BIT_I];
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RST_I);
  sequence s_req(iod_pkg::iod_op_t o, logic [7:0] a);
    ACC_VALID_I && ACC_OP_I == o && ACC_ADDR_I == a;
  endsequence
  sequence s_bitop(logic [7:0] a);
    ACC_VALID_I && ACC_OP_I inside {iod_pkg::OP_SETB, iod_pkg::OP_CLRB} && ACC_ADDR_I == a;
  endsequence
  chk_in_read: assert property (s_req(iod_pkg::OP_IN, 8'h05) |=> ACC_RVALID_O && ACC_RDATA_O == $past(OUT_B_O))
    else $error("io read");
  chk_out_map: assert property (s_req(iod_pkg::OP_OUT, 8'h05) |=> OUT_B_O == $past(ACC_WDATA_I))
    else $error("io write");
  chk_store_map: assert property (s_req(iod_pkg::OP_STORE, 8'h25) |=> OUT_B_O == $past(ACC_WDATA_I))
    else $error("data write");
  chk_ext_load: assert property (ext_req && ACC_OP_I == iod_pkg::OP_LOAD |=> !EXT_WR_O && EXT_ADDR_O == $past(ACC_ADDR_I))
    else $error("ext load");
  chk_ext_store: assert property (ext_req && ACC_OP_I == iod_pkg::OP_STORE |=> EXT_WR_O && EXT_WDATA_O == $past(ACC_WDATA_I))
    else $error("ext store");
  chk_ext_cause: assert property (EXT_SEL_O |-> $past(ext_req))
    else $error("ext select");
  chk_setb_bit: assert property (s_req(iod_pkg::OP_SETB, 8'h05) |=> OUT_B_O == ($past(OUT_B_O) | (8'h01 << $past(ACC_BIT_I))))
    else $error("bit set");
  chk_clrb_bit: assert property (s_req(iod_pkg::OP_CLRB, 8'h05) |=> OUT_B_O == ($past(OUT_B_O) & ~(8'h01 << $past(ACC_BIT_I))))
    else $error("bit clear");
  chk_bitop_high: assert property (s_bitop(8'h20) |=> $stable(NVM_DATA_O))
    else $error("bit op high");
  chk_test_bit: assert property (s_req(iod_pkg::OP_TESTB, 8'h05) |=> BIT_TEST_O == $past(sel_bit))
    else $error("bit test");
  chk_rsvd_read: assert property (s_req(iod_pkg::OP_IN, 8'h00) |=> ACC_RDATA_O == 8'h00)
    else $error("reserved read");
endmodule

/* File: iod_core_model.sv */
`timescale 1ns/100ps
module iod_core_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       bit_i,
  output logic            valid_o,
  output iod_pkg::iod_op_t op_o,
  output logic [7:0]      addr_o,
  output logic [2:0]      bsel_o,
  output logic [7:0]      wdata_o
);
  logic [7:0] rd;
  logic       bt;
  initial begin
    valid_o = 1'b0;
    op_o = iod_pkg::OP_NONE;
    addr_o = 8'h00;
    bsel_o = 3'h0;
    wdata_o = 8'h00;
  end
  // Called at a falling edge; the answer is taken at the next one
  task automatic acc(input iod_pkg::iod_op_t o, input logic [7:0] a,
                     input logic [2:0] b = 3'h0, input logic [7:0] d = 8'h00);
    valid_o = 1'b1;
    op_o = o;
    addr_o = a;
    bsel_o = b;
    wdata_o = d;
    @(negedge clk_i);
    rd = rdata_i;
    bt = bit_i;
  endtask
  // Released bus shows no stale address
  task automatic idle();
    valid_o = 1'b0;
    addr_o = ~addr_o;
    @(negedge clk_i);
  endtask
endmodule

/* File: iod_regs_tb.sv */
`timescale 1ns/100ps
`define CHK(a, e) \
  begin \
    num_checks++; \
    if ((a) !== (e)) begin \
      mismatches++; \
      $display("[ERR] %0t got %h exp %h", $time, (a), (e)); \
    end \
  end
module iod_regs_tb;
  logic             SYS_CLK_I = 1'b0;
  logic             RST_I = 1'b1;
  logic             ACC_VALID_I;
  iod_pkg::iod_op_t ACC_OP_I;
  logic [7:0]       ACC_ADDR_I;
  logic [2:0]       ACC_BIT_I;
  logic [7:0]       ACC_WDATA_I;
  logic [7:0]       ACC_RDATA_O;
  logic             BIT_TEST_O;
  logic             EXT_SEL_O;
  logic             EXT_WR_O;
  logic [7:0]       EXT_ADDR_O;
  logic [7:0]       EXT_WDATA_O;
  logic [7:0]       EXT_RDATA_I;
  logic             ACC_RVALID_O;
  logic [7:0]       regs_o [18];
  // Writable registers in the order of regs_o, with their implemented bits
  logic [7:0]       wa [18] = '{8'h0D, 8'h04, 8'h07, 8'h0A, 8'h0E, 8'h05, 8'h08, 8'h0B, 8'h12,
                                8'h1D, 8'h1F, 8'h20, 8'h21, 8'h23, 8'h25, 8'h26, 8'h27, 8'h28};
  logic [7:0]       wm [18] = '{iod_pkg::M_PA, 8'hFF, 8'hFF, 8'hFF, iod_pkg::M_PA, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                iod_pkg::M_EXM, iod_pkg::M_NVMC, 8'hFF, 8'hFF, iod_pkg::M_TPS, iod_pkg::M_T0C,
                                8'hFF, 8'hFF, 8'hFF};
  logic [7:0]       pins = 8'h00;
  logic [7:0]       fset = 8'h00;
  logic [7:0]       bank [4] = '{8'h05, 8'h1E, 8'h2A, 8'h2B};
  logic [7:0]       rsv [3] = '{8'h00, 8'h13, 8'h29};
  logic [7:0]       fa [4] = '{8'h15, 8'h16, 8'h1B, 8'h1C};
  logic [7:0]       fm [4] = '{iod_pkg::M_T0F, iod_pkg::M_T1F, iod_pkg::M_PCF, iod_pkg::M_EXF};
  int               mismatches = 0;
  int               num_checks = 0;
  always #2.5 SYS_CLK_I = ~SYS_CLK_I;
  assign EXT_RDATA_I = ~ACC_ADDR_I;
  iod_regs u_dut (
    .SYS_CLK_I, .RST_I, .ACC_VALID_I, .ACC_OP_I, .ACC_ADDR_I, .ACC_BIT_I, .ACC_WDATA_I, .EXT_RDATA_I,
    .PIN_A_I(pins), .PIN_B_I(pins), .PIN_C_I(pins), .PIN_D_I(pins), .T0_FLAG_SET_I(fset),
    .T1_FLAG_SET_I(fset), .PC_FLAG_SET_I(fset), .EX_FLAG_SET_I(fset), .ACC_RDATA_O, .ACC_RVALID_O,
    .BIT_TEST_O, .EXT_SEL_O, .EXT_WR_O, .EXT_ADDR_O, .EXT_WDATA_O, .DIR_A_O(regs_o[0]), .DIR_B_O(regs_o[1]),
    .DIR_C_O(regs_o[2]), .DIR_D_O(regs_o[3]), .OUT_A_O(regs_o[4]), .OUT_B_O(regs_o[5]), .OUT_C_O(regs_o[6]),
    .OUT_D_O(regs_o[7]), .PULL_CTRL_O(regs_o[8]), .EX_MASK_O(regs_o[9]), .NVM_CTRL_O(regs_o[10]),
    .NVM_DATA_O(regs_o[11]), .NVM_ADDR_O(regs_o[12]), .TPS_CTRL_O(regs_o[13]), .T0_CTRL_O(regs_o[14]),
    .T0_COUNT_O(regs_o[15]), .T0_CMPA_O(regs_o[16]), .T0_CMPB_O(regs_o[17])
  );
  iod_core_model u_core (
    .clk_i(SYS_CLK_I), .rdata_i(ACC_RDATA_O), .bit_i(BIT_TEST_O), .valid_o(ACC_VALID_I),
    .op_o(ACC_OP_I), .addr_o(ACC_ADDR_I), .bsel_o(ACC_BIT_I), .wdata_o(ACC_WDATA_I)
  );
  task automatic t_bank();
    foreach (bank[i]) begin
      u_core.acc(iod_pkg::OP_OUT, bank[i], 3'h0, 8'hA0 + 8'(i));
      u_core.acc(iod_pkg::OP_IN, bank[i]);
      `CHK(u_core.rd, 8'hA0 + 8'(i))
      u_core.acc(iod_pkg::OP_LOAD, bank[i] + 8'h20);
      `CHK(u_core.rd, 8'hA0 + 8'(i))
      u_core.acc(iod_pkg::OP_STORE, bank[i] + 8'h20, 3'h0, 8'h3C);
      u_core.acc(iod_pkg::OP_IN, bank[i]);
      `CHK(u_core.rd, 8'h3C)
    end
    // Deliberate writes to reserved places
    foreach (rsv[i]) begin
      u_core.acc(iod_pkg::OP_OUT, rsv[i], 3'h0, 8'hFF);
      u_core.acc(iod_pkg::OP_IN, rsv[i]);
      `CHK(u_core.rd, 8'h00)
    end
  endtask
  task automatic t_ext();
    u_core.acc(iod_pkg::OP_LOAD, 8'h60);
    `CHK({ACC_RVALID_O, EXT_SEL_O, EXT_WR_O, EXT_ADDR_O, u_core.rd}, {3'b110, 8'h60, 8'h9F})
    u_core.acc(iod_pkg::OP_STORE, 8'hFF, 3'h0, 8'h77);
    `CHK({ACC_RVALID_O, EXT_SEL_O, EXT_WR_O, EXT_WDATA_O}, {3'b011, 8'h77})
    u_core.acc(iod_pkg::OP_IN, 8'h60);
    `CHK({ACC_RVALID_O, EXT_SEL_O, u_core.rd}, 10'h200)
    // Data addresses below the I/O window are not this block's
    u_core.acc(iod_pkg::OP_STORE, 8'h05, 3'h0, 8'h55);
    u_core.acc(iod_pkg::OP_LOAD, 8'h05);
    `CHK({EXT_SEL_O, u_core.rd}, 9'h000)
    u_core.acc(iod_pkg::OP_IN, 8'h05);
    `CHK(u_core.rd, 8'h3C)
  endtask
  task automatic t_bits();
    u_core.acc(iod_pkg::OP_OUT, 8'h05, 3'h0, 8'h0F);
    u_core.acc(iod_pkg::OP_SETB, 8'h05, 3'h7);
    u_core.acc(iod_pkg::OP_CLRB, 8'h05, 3'h0);
    u_core.acc(iod_pkg::OP_TESTB, 8'h05, 3'h7);
    `CHK(u_core.bt, 1'b1)
    u_core.acc(iod_pkg::OP_TESTB, 8'h05, 3'h0);
    `CHK(u_core.bt, 1'b0)
    u_core.acc(iod_pkg::OP_IN, 8'h05);
    `CHK(u_core.rd, 8'h8E)
    u_core.acc(iod_pkg::OP_OUT, 8'h20, 3'h0, 8'h00);
    u_core.acc(iod_pkg::OP_SETB, 8'h20, 3'h3);
    u_core.acc(iod_pkg::OP_IN, 8'h20);
    `CHK(u_core.rd, 8'h00)
  endtask
  task automatic t_flags();
    fset = 8'hFF;
    u_core.idle();
    fset = 8'h00;
    foreach (fa[i]) begin
      u_core.acc(iod_pkg::OP_OUT, fa[i], 3'h0, 8'h00);
      u_core.acc(iod_pkg::OP_IN, fa[i]);
      `CHK(u_core.rd, fm[i])
      u_core.acc(iod_pkg::OP_SETB, fa[i], 3'h0);
      u_core.acc(iod_pkg::OP_CLRB, fa[i], 3'h1);
      u_core.acc(iod_pkg::OP_IN, fa[i]);
      `CHK(u_core.rd, fm[i] & 8'hFE)
      u_core.acc(iod_pkg::OP_OUT, fa[i], 3'h0, fm[i]);
      u_core.acc(iod_pkg::OP_IN, fa[i]);
      `CHK(u_core.rd, 8'h00)
    end
  endtask
  task automatic t_pins();
    pins = 8'hA5;
    repeat (3) @(negedge SYS_CLK_I);
    u_core.acc(iod_pkg::OP_OUT, 8'h03, 3'h0, 8'h00);
    u_core.acc(iod_pkg::OP_IN, 8'h03);
    `CHK(u_core.rd, 8'hA5)
    u_core.acc(iod_pkg::OP_LOAD, 8'h2C);
    `CHK(u_core.rd, 8'hA5 & iod_pkg::M_PA)
    u_core.acc(iod_pkg::OP_IN, 8'h06);
    `CHK(u_core.rd, 8'hA5)
    u_core.acc(iod_pkg::OP_LOAD, 8'h29);
    `CHK(u_core.rd, 8'hA5)
  endtask
  task automatic t_outs();
    foreach (wa[i]) begin
      u_core.acc(iod_pkg::OP_OUT, wa[i], 3'h0, (8'hC3 ^ 8'(i)) & wm[i]);
      `CHK(regs_o[i], (8'hC3 ^ 8'(i)) & wm[i])
    end
  endtask
  task automatic complete_run();
    if (mismatches == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge SYS_CLK_I);
    RST_I = 1'b0;
    t_bank();
    t_ext();
    t_bits();
    t_flags();
    t_pins();
    t_outs();
    u_core.idle();
    complete_run();
  end
  // About 92 accesses are planned; this leaves ample margin
  initial begin
    #20000;
    mismatches++;
    complete_run();
  end
endmodule
bind iod_regs iod_regs_assertions u_chk (
  .SYS_CLK_I, .RST_I, .ACC_VALID_I, .ACC_OP_I, .ACC_ADDR_I, .ACC_BIT_I, .ACC_WDATA_I, .ACC_RDATA_O,
  .ACC_RVALID_O, .BIT_TEST_O, .EXT_SEL_O, .EXT_WR_O, .EXT_ADDR_O, .EXT_WDATA_O, .OUT_B_O, .NVM_DATA_O
);
